// File: hw/adc_pkg.sv
package adc_pkg;
  // reset and settle timing
  localparam int POR_CYCLES = 1024; // core cycles held in reset after supply good
  localparam int VALID_PERIODS = 4480; // sample periods before data is valid
  // clock ratios in multiples of the sample rate
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;
  localparam logic [10:0] TICK_STEP = 11'h100; // divided clock is 256 fs
  localparam logic [7:0] TICK_LAST = 8'hFF; // 256 divided ticks per sample
  // interface select codes {hi, lo}
  localparam logic [1:0] MODE_SLAVE = 2'h0;
  localparam logic [1:0] MODE_M512 = 2'h1;
  localparam logic [1:0] MODE_M384 = 2'h2;
  localparam logic [1:0] MODE_M256 = 2'h3;
  // format select codes {hi, lo}
  localparam logic [1:0] FMT_LJ24 = 2'h0;
  localparam logic [1:0] FMT_I2S24 = 2'h1;
  localparam logic [1:0] FMT_RJ24 = 2'h2;
  localparam logic [1:0] FMT_RJ20 = 2'h3;
  localparam logic [5:0] WORD_24 = 6'h18;
  localparam logic [5:0] WORD_20 = 6'h14;
  localparam logic [5:0] HALF_MASTER = 6'h20; // 32 bit slots per half frame
  // slave frame lengths and drift limits in bit clocks
  localparam logic [6:0] FRAME_48 = 7'h30;
  localparam logic [17:0] MUL_64 = 18'h00040;
  localparam logic [17:0] MUL_48 = 18'h00030;
  localparam logic [17:0] DRIFT_64 = 18'h00006;
  localparam logic [17:0] DRIFT_48 = 18'h00005;
  localparam int HPF_SHIFT = 10; // dc tracking time constant
  // serial pin group
  typedef struct packed {
    logic bclk;
    logic frame;
    logic sync;
  } link_pins_type;
  // one stereo sample
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } sample_pair_type;
  // conversion sequence
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10,
    ST_UNSYNC = 2'b11
  } run_state_type;
endpackage : adc_pkg

// File: hw/stereo_adc_serial_audio_port.sv
`timescale 1ns/1ns
// sample buffer between decimator and serializer
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW-1:0] wr_q; // write index
  logic [AW-1:0] rd_q; // read index
  logic [AW:0] cnt_q; // fill level
  logic push;
  logic pop;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// Contract
// - slave mode auto-detects 256/384/512/768 fs clock
// - divide system clock down to 256 fs
// - hold reset 1024 cycles, output zero
// - data valid after 4480 sample periods
// - mode pins pick slave or master ratio
// - master drives bit, frame, sync clocks
// - master sync spans each sample's bits
// - master bit clock is 64 per frame
// - slave shifts only while sync high
// - slave accepts 64 or 48 bits per frame
// - format pins pick LJ, I2S, RJ24, RJ20
// - decimate bitstream to one word per period
// - dc removal then multiplexed serial output
// - frame drift halts output to zero
// - power down stops logic, disables data
// - bypass pin skips dc removal
// - oversample pin picks 64 or 128
module stereo_adc_serial_audio_port #(
  parameter int VALID_PERIODS = adc_pkg::VALID_PERIODS,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_down_n,
  input wire logic dc_filter_bypass,
  input wire logic oversample_ratio_sel,
  input wire logic interface_select_hi,
  input wire logic interface_select_lo,
  input wire logic format_select_hi,
  input wire logic format_select_lo,
  input wire logic mod_left_bit,
  input wire logic mod_right_bit,
  input wire logic serial_bit_clock_in,
  input wire logic channel_frame_clock_in,
  input wire logic data_valid_sync_in,
  output adc_pkg::link_pins_type link_out,
  output adc_pkg::link_pins_type link_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic modulator_strobe,
  output logic samples_valid,
  output logic sync_lost
);
  import adc_pkg::*;

  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw; // all control and link input pins
  logic [NPIN-1:0] s1_q; // first stage, read only by second
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] pin_q; // accepted pin levels
  logic [2:0] link_prev_q; // last accepted bit, frame, sync
  assign pin_raw = {power_down_n, dc_filter_bypass, oversample_ratio_sel,
    interface_select_hi, interface_select_lo, format_select_hi, format_select_lo,
    serial_bit_clock_in, channel_frame_clock_in, data_valid_sync_in};

  // three-stage pin synchroniser, change taken when stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
    end
  end

  logic pd_n; // running when high
  logic bypass;
  logic osr128;
  logic [1:0] mode;
  logic [1:0] fmt;
  logic is_master;
  logic bck_fall;
  logic bck_rise;
  logic channel_frame_clock_edge;
  logic channel_frame_clock_rise;
  assign pd_n = pin_q[9];
  assign bypass = pin_q[8];
  assign osr128 = pin_q[7];
  assign mode = pin_q[6:5];
  assign fmt = pin_q[4:3];
  assign is_master = mode != MODE_SLAVE;
  assign bck_rise = pin_q[2] && !link_prev_q[2];
  assign bck_fall = !pin_q[2] && link_prev_q[2];
  assign channel_frame_clock_edge = pin_q[1] != link_prev_q[1];
  assign channel_frame_clock_rise = pin_q[1] && !link_prev_q[1];

  // edge history of slave pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) link_prev_q <= 3'h0;
    else link_prev_q <= pin_q[2:0];
  end

  // nearest supported ratio of a measured frame length
  function automatic logic [9:0] classify(input logic [10:0] p);
    if (p < 11'h0C0) classify = 10'h000;
    else if (p < 11'h140) classify = RATIO_256;
    else if (p < 11'h1C0) classify = RATIO_384;
    else if (p < 11'h280) classify = RATIO_512;
    else if (p < 11'h380) classify = RATIO_768;
    else classify = 10'h000;
  endfunction : classify

  logic [10:0] period_cnt_q; // core cycles in current frame
  logic [6:0] bits_cnt_q; // bit clocks in current frame
  logic [6:0] frame_bits_q; // bit clocks in last frame
  logic [9:0] ratio_q; // locked slave ratio, zero when unlocked
  logic sync_lost_q;
  logic [10:0] meas;
  logic [10:0] diff;
  logic [17:0] lhs;
  logic [17:0] rhs;
  logic drift;
  // drift test of last frame against the locked ratio
  always_comb begin
    meas = period_cnt_q + 11'h001;
    diff = (meas > {1'b0, ratio_q}) ? meas - {1'b0, ratio_q} : {1'b0, ratio_q} - meas;
    if (frame_bits_q == FRAME_48) begin
      lhs = {7'h00, diff} * MUL_48;
      rhs = {8'h00, ratio_q} * DRIFT_48;
    end else begin
      lhs = {7'h00, diff} * MUL_64;
      rhs = {8'h00, ratio_q} * DRIFT_64;
    end
    drift = lhs > rhs;
  end

  // slave clock ratio detection and frame length
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= 11'h000;
      bits_cnt_q <= 7'h00;
      frame_bits_q <= 7'h40;
      ratio_q <= 10'h000;
      sync_lost_q <= 1'b0;
    end else if (!pd_n || is_master) begin
      period_cnt_q <= 11'h000;
      bits_cnt_q <= 7'h00;
      ratio_q <= 10'h000;
      sync_lost_q <= 1'b0;
    end else if (channel_frame_clock_rise) begin
      period_cnt_q <= 11'h000;
      bits_cnt_q <= 7'h00;
      frame_bits_q <= bits_cnt_q;
      if (ratio_q == 10'h000) begin
        ratio_q <= classify(meas);
      end else if (drift) begin
        ratio_q <= classify(meas);
        sync_lost_q <= 1'b1;
      end else begin
        sync_lost_q <= 1'b0;
      end
    end else begin
      if (period_cnt_q != 11'h7FF) period_cnt_q <= period_cnt_q + 11'h001;
      if (bck_rise && bits_cnt_q != 7'h7F) bits_cnt_q <= bits_cnt_q + 7'h01;
    end
  end

  logic [9:0] eff_ratio; // ratio in use
  // master ratio from mode pins, slave ratio from detector
  always_comb begin
    case (mode)
      MODE_M512: eff_ratio = RATIO_512;
      MODE_M384: eff_ratio = RATIO_384;
      MODE_M256: eff_ratio = RATIO_256;
      default: eff_ratio = ratio_q;
    endcase
  end

  logic [10:0] div_acc_q; // fractional divider accumulator
  logic [10:0] div_sum;
  logic tick; // 256 fs tick
  logic [7:0] tick_cnt_q; // ticks within sample period
  logic strobe_q; // modulator bit strobe
  logic sample_end;
  assign div_sum = div_acc_q + TICK_STEP;
  assign tick = pd_n && eff_ratio != 10'h000 && div_sum >= {1'b0, eff_ratio};
  assign sample_end = tick && tick_cnt_q == TICK_LAST;

  // divide system clock to 256 fs and strobe the modulator at 64 or 128 fs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_acc_q <= 11'h000;
      tick_cnt_q <= 8'h00;
      strobe_q <= 1'b0;
    end else if (!pd_n) begin
      div_acc_q <= 11'h000;
      tick_cnt_q <= 8'h00;
      strobe_q <= 1'b0;
    end else begin
      if (tick) begin
        div_acc_q <= div_sum - {1'b0, eff_ratio};
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end else if (eff_ratio != 10'h000) begin
        div_acc_q <= div_sum;
      end
      strobe_q <= tick && (osr128 ? !tick_cnt_q[0] : tick_cnt_q[1:0] == 2'h0);
    end
  end

  run_state_type state_q;
  logic [9:0] por_cnt_q;
  logic [12:0] settle_cnt_q;
  // reset hold, settle count and sync loss handling
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      por_cnt_q <= 10'h000;
      settle_cnt_q <= 13'h0000;
    end else if (!pd_n) begin
      state_q <= ST_RESET;
      por_cnt_q <= 10'h000;
    end else begin
      case (state_q)
        ST_RESET: begin
          por_cnt_q <= por_cnt_q + 10'h001;
          settle_cnt_q <= 13'h0000;
          if (por_cnt_q == 10'(POR_CYCLES - 1)) state_q <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // the first boundary may come at once, so one more is counted for whole periods
          if (sample_end) begin
            settle_cnt_q <= settle_cnt_q + 13'h0001;
            if (settle_cnt_q == 13'(VALID_PERIODS)) state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sync_lost_q) state_q <= ST_UNSYNC;
        end
        ST_UNSYNC: begin
          if (!sync_lost_q) state_q <= ST_RUN;
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end

  logic run;
  logic [1:0] mod_bits;
  logic signed [23:0] chan_word [2]; // filtered words per channel
  assign run = state_q == ST_RUN;
  assign mod_bits = {mod_right_bit, mod_left_bit};

  // per channel boxcar decimator and dc removal
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [8:0] integ_q; // bitstream sum over one period
    logic signed [23:0] dc_q; // running dc estimate
    logic signed [8:0] integ_n;
    logic signed [23:0] raw;
    logic signed [23:0] hp;
    always_comb begin
      integ_n = integ_q + (strobe_q ? (mod_bits[ch] ? 9'h001 : 9'h1FF) : 9'h000);
      raw = osr128 ? {integ_n, 15'h0000} : {integ_n[7:0], 16'h0000};
      hp = raw - dc_q;
      chan_word[ch] = bypass ? raw : hp;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        integ_q <= 9'h000;
        dc_q <= 24'h000000;
      end else if (!pd_n) begin
        integ_q <= 9'h000;
      end else if (sample_end) begin
        integ_q <= 9'h000;
        dc_q <= dc_q + (hp >>> HPF_SHIFT);
      end else begin
        integ_q <= integ_n;
      end
    end
  end

  sample_pair_type pend_q; // word waiting for buffer space
  logic pend_valid_q;
  logic fifo_in_ready;
  logic [47:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  // hand samples to the buffer, holding while it is full
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
      pend_valid_q <= 1'b0;
    end else if (sample_end) begin
      pend_q.left <= run ? chan_word[0] : 24'h000000;
      pend_q.right <= run ? chan_word[1] : 24'h000000;
      pend_valid_q <= 1'b1;
    end else if (fifo_in_ready) begin
      pend_valid_q <= 1'b0;
    end
  end

  sample_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(pend_q),
    .in_valid(pend_valid_q),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  logic [5:0] word_len;
  logic [5:0] half_len;
  logic [5:0] data_start;
  assign word_len = (fmt == FMT_RJ20) ? WORD_20 : WORD_24;
  assign half_len = is_master ? HALF_MASTER : frame_bits_q[6:1];
  // first data slot of a half frame
  always_comb begin
    case (fmt)
      FMT_LJ24: data_start = 6'h00;
      FMT_I2S24: data_start = 6'h01;
      default: data_start = half_len - word_len;
    endcase
  end

  // slot inside data window, msb first, zero elsewhere
  function automatic logic slot_bit(input logic [23:0] w, input logic [5:0] p,
      input logic [5:0] st, input logic [5:0] wl);
    logic [5:0] k;
    k = p - st;
    if (p >= st && k < wl) slot_bit = w[5'(6'h17 - k)];
    else slot_bit = 1'b0;
  endfunction : slot_bit

  logic [2:0] half_cnt_q; // core cycles in half bit clock
  logic [5:0] bit_pos_q; // master bit slot within frame
  logic [5:0] pos_q; // slot within half frame
  logic bclk_q;
  logic frame_q;
  logic sync_q;
  logic sdata_q;
  sample_pair_type cur_q; // pair being sent
  logic master_fall;
  logic [5:0] bit_pos_n;
  logic slave_shift;
  logic left_half;
  logic [23:0] half_word;
  assign master_fall = is_master && bclk_q && half_cnt_q == eff_ratio[9:7] - 3'h1;
  assign bit_pos_n = bit_pos_q + 6'h01;
  assign slave_shift = !is_master && bck_fall && pin_q[0];
  assign left_half = (fmt == FMT_I2S24) ? !pin_q[1] : pin_q[1];
  assign fifo_pop = (master_fall && bit_pos_n == 6'h00) ||
    (!is_master && channel_frame_clock_edge && left_half);
  // a pop loads cur_q at the same edge, so its first bit comes straight from the buffer
  assign half_word = fifo_pop ? ((fifo_out_valid && run) ? fifo_out[47:24] : 24'h000000) :
    ((is_master ? !bit_pos_n[5] : left_half) ? cur_q.left : cur_q.right);

  // bit clock divider and serial shifter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_q <= 3'h0;
      bit_pos_q <= 6'h3F;
      pos_q <= 6'h00;
      bclk_q <= 1'b0;
      frame_q <= 1'b0;
      sync_q <= 1'b0;
      sdata_q <= 1'b0;
      cur_q <= '0;
    end else if (!pd_n) begin
      half_cnt_q <= 3'h0;
      bclk_q <= 1'b0;
      sync_q <= 1'b0;
      sdata_q <= 1'b0;
    end else begin
      if (fifo_pop) cur_q <= (fifo_out_valid && run) ? fifo_out : '0;
      else if (!run) cur_q <= '0;
      if (is_master) begin
        if (half_cnt_q == eff_ratio[9:7] - 3'h1) begin
          half_cnt_q <= 3'h0;
          bclk_q <= !bclk_q;
        end else begin
          half_cnt_q <= half_cnt_q + 3'h1;
        end
        if (master_fall) begin
          bit_pos_q <= bit_pos_n;
          pos_q <= {1'b0, bit_pos_n[4:0]};
          frame_q <= (fmt == FMT_I2S24) ? bit_pos_n[5] : !bit_pos_n[5];
          sync_q <= {1'b0, bit_pos_n[4:0]} >= data_start &&
            {1'b0, bit_pos_n[4:0]} - data_start < word_len;
          sdata_q <= run && slot_bit(half_word, {1'b0, bit_pos_n[4:0]}, data_start, word_len);
        end
      end else if (channel_frame_clock_edge) begin
        pos_q <= 6'h00;
        sdata_q <= run && slot_bit(half_word, 6'h00, data_start, word_len);
      end else if (slave_shift) begin
        pos_q <= pos_q + 6'h01;
        sdata_q <= run && slot_bit(half_word, pos_q + 6'h01, data_start, word_len);
      end
      if (!run) sdata_q <= 1'b0;
    end
  end

  // pin drive and status outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_out <= '0;
      link_oe <= '0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      modulator_strobe <= 1'b0;
      samples_valid <= 1'b0;
      sync_lost <= 1'b0;
    end else begin
      link_out <= '{bclk: bclk_q, frame: frame_q, sync: sync_q};
      link_oe <= (is_master && pd_n) ? 3'h7 : 3'h0;
      serial_data_out <= sdata_q;
      serial_data_oe <= pd_n;
      modulator_strobe <= strobe_q;
      samples_valid <= run;
      sync_lost <= sync_lost_q;
    end
  end

  AST_ZERO_OUT: assert property (@(posedge core_clk) disable iff (!rst_n)
    !run |=> !sdata_q) else $error("data not zero outside run");
  AST_POR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_RESET && por_cnt_q != 10'h3FF |=> state_q == ST_RESET)
    else $error("reset left early");
  AST_SETTLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ST_SETTLE |=> !samples_valid) else $error("valid during settle");
  AST_DIV512: assert property (@(posedge core_clk) disable iff (!rst_n)
    eff_ratio == RATIO_512 && $stable(eff_ratio) && tick |=> !tick)
    else $error("512 fs divide wrong");
  AST_BITSTEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_master && $past(is_master) && $changed(bit_pos_q) |-> bit_pos_q == $past(bit_pos_q) + 6'h01)
    else $error("master bit slot skipped");
  AST_FALL_ALIGN: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_master && $past(pd_n) && $changed(sync_q) |-> $fell(bclk_q))
    else $error("sync not on falling edge");
  AST_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !is_master && !pin_q[0] && !channel_frame_clock_edge && run |=> $stable(pos_q))
    else $error("slave shifted without sync");
  AST_DRIFT: assert property (@(posedge core_clk) disable iff (!rst_n)
    run && sync_lost_q && pd_n |=> state_q == ST_UNSYNC) else $error("drift not halted");
  AST_PD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pd_n |=> !serial_data_oe ##1 state_q == ST_RESET) else $error("power down ignored");
  AST_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_master && pd_n |=> link_oe == 3'h7) else $error("master pins not driven");
  AST_RATIO: assert property (@(posedge core_clk) disable iff (!rst_n)
    ratio_q == 10'h000 || ratio_q == RATIO_256 || ratio_q == RATIO_384 ||
    ratio_q == RATIO_512 || ratio_q == RATIO_768) else $error("bad locked ratio");
  COV_RUN: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(run));
  COV_LOST: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(sync_lost_q));
  COV_FULL: cover property (@(posedge core_clk) disable iff (!rst_n) !fifo_in_ready);
endmodule : stereo_adc_serial_audio_port

// File: tb/audio_host_model.sv
`timescale 1ns/1ns
// audio controller clocking the port in slave mode, 256 fs core clock
module audio_host_model (
  input wire logic core_clk,
  input wire logic run,
  output logic bclk,
  output logic frame,
  output logic sync
);
  logic [7:0] cnt_q; // core cycles within one frame
  initial cnt_q = 8'h00;
  // pins move on the falling edge; clocks stand still while not running
  always @(negedge core_clk) begin
    if (run) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign bclk = run & cnt_q[1];
  assign frame = ~cnt_q[7];
  assign sync = run & (cnt_q[6:2] < 5'h18);
endmodule : audio_host_model

// File: tb/test_stereo_adc_serial_audio_port.sv
`timescale 1ns/1ns
module test_stereo_adc_serial_audio_port;
  import adc_pkg::*;
  logic core_clk, rst_n, power_down_n, dc_filter_bypass, oversample_ratio_sel;
  logic [1:0] mode, fmt; // interface and format pins {hi, lo}
  logic mod_left_bit, mod_right_bit, host_run, host_bclk, host_frame, host_sync;
  link_pins_type link_out, link_oe, pins; // pins is the resolved wire level
  logic serial_data_out, serial_data_oe, modulator_strobe, samples_valid, sync_lost;
  logic [31:0] rnd, me, mg;
  logic [31:0] exp_q[$], got_q[$]; // expected notes and observed results
  int err_count, n_checks, cycles, c, br, sr, sh, nz, st;
  logic [1:0] mode_t[4] = '{MODE_M256, MODE_M512, MODE_M384, MODE_M256};
  logic [9:0] ratio_t[4] = '{RATIO_256, RATIO_512, RATIO_384, RATIO_256};
  assign pins.bclk = link_oe.bclk ? link_out.bclk : host_bclk;
  assign pins.frame = link_oe.frame ? link_out.frame : host_frame;
  assign pins.sync = link_oe.sync ? link_out.sync : host_sync;
  stereo_adc_serial_audio_port #(.VALID_PERIODS(4)) i_stereo_adc_serial_audio_port (
    .core_clk(core_clk), .rst_n(rst_n), .power_down_n(power_down_n),
    .dc_filter_bypass(dc_filter_bypass), .oversample_ratio_sel(oversample_ratio_sel),
    .interface_select_hi(mode[1]), .interface_select_lo(mode[0]),
    .format_select_hi(fmt[1]), .format_select_lo(fmt[0]),
    .mod_left_bit(mod_left_bit), .mod_right_bit(mod_right_bit),
    .serial_bit_clock_in(pins.bclk), .channel_frame_clock_in(pins.frame),
    .data_valid_sync_in(pins.sync), .link_out(link_out), .link_oe(link_oe),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .modulator_strobe(modulator_strobe), .samples_valid(samples_valid),
    .sync_lost(sync_lost));
  audio_host_model i_audio_host_model (.core_clk(core_clk), .run(host_run),
    .bclk(host_bclk), .frame(host_frame), .sync(host_sync));
  // xorshift source for modulator bits and the bypass pin
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // new modulator bits just after each strobe, so they hold around the next one
  always @(negedge core_clk) begin
    if (modulator_strobe === 1'b1) begin
      rnd <= xs(rnd);
      mod_left_bit <= rnd[0];
      mod_right_bit <= rnd[9];
    end
  end
  // oldest note against oldest result
  always @(posedge core_clk) begin
    if (got_q.size() > 0) begin
      me = exp_q.pop_front();
      mg = got_q.pop_front();
      n_checks++;
      if (mg !== me) begin
        err_count++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, me, mg);
      end
    end
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : note
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // power cycle, then time the way to valid data
  task automatic restart(input logic [9:0] ratio);
    int n;
    int z;
    n = 0;
    z = 0;
    power_down_n = 1'b0;
    repeat (8) @(negedge core_clk);
    note(1'b0, serial_data_oe);
    note(3'h0, link_oe);
    power_down_n = 1'b1;
    while (samples_valid !== 1'b1 && n < 9000) begin
      @(negedge core_clk);
      n++;
      z += (serial_data_out !== 1'b0);
    end
    note(0, z);
    note(1, (n >= 1024 + 4 * ratio) && (n <= 1040 + 5 * ratio));
  endtask : restart
  // one frame between two frame rises, seen on the resolved pins
  task automatic measure();
    int fr;
    link_pins_type p;
    {fr, c, br, sr, sh, nz, st} = '0;
    while (fr < 2 && c < 9000) begin
      p = pins;
      @(negedge core_clk);
      fr += (pins.frame && !p.frame);
      if (fr == 1) begin
        c++;
        sr += (pins.sync && !p.sync);
        st += modulator_strobe;
        if (pins.bclk && !p.bclk) begin
          br++;
          sh += pins.sync;
          nz += (!pins.sync && serial_data_out);
        end
      end
    end
  endtask : measure
  initial begin
    {rst_n, power_down_n, dc_filter_bypass, oversample_ratio_sel} = 4'h4;
    {mode, fmt, mod_left_bit, mod_right_bit, host_run} = '0;
    {err_count, n_checks, cycles} = '0;
    rnd = 32'h14;
    repeat (6) @(negedge core_clk);
    note(3'h0, link_oe);
    note(1'b0, serial_data_out);
    rst_n = 1'b1;
    // every master ratio and every format, both oversampling ratios
    for (int i = 0; i < 4; i++) begin
      mode = mode_t[i];
      fmt = 2'(i);
      oversample_ratio_sel = i[0];
      dc_filter_bypass = rnd[3];
      restart(ratio_t[i]);
      note(3'h7, link_oe);
      measure();
      note(32'(ratio_t[i]), c);
      note(64, br);
      note(2, sr);
      note((fmt == FMT_RJ20) ? 40 : 48, sh);
      note(0, nz);
      note(i[0] ? 128 : 64, st);
      $display("master test %0d done", i);
    end
    // slave mode clocked by the partner at 256 fs
    mode = MODE_SLAVE;
    fmt = FMT_LJ24;
    oversample_ratio_sel = 1'b0;
    host_run = 1'b1;
    restart(RATIO_256);
    note(3'h0, link_oe);
    measure();
    note(256, c);
    note(64, br);
    note(64, st);
    note(1'b0, sync_lost);
    note(1'b1, samples_valid);
    $display("slave test done");
    repeat (20) @(negedge core_clk);
    summarize();
  end
endmodule : test_stereo_adc_serial_audio_port
